/* File: src/sdr_ram.sv */
// Contract
// - Array holds 576 bits including parity; parity bits usable or unused.
// - One write port and one independent read port, never two full ports.
// - Modes: simple dual-port, single-port, FIFO, ROM and shift register.
// - Shapes 512x1, 256x2, 128x4, 64x8, 64x9, 32x16, 32x18.
// - In RAM or ROM mode contents can be preloaded before operation.
// - Write enable, data and address registers share one selected clock.
// - Read address, read enable and output registers each pick either clock.
// - Output register may be bypassed; other input registers always present.
// - Per-clock enables and an asynchronous clear are accepted.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sdr_consts.svh"

module sdr_ram (
   input wire logic clock, // System clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic [3:0] awaddr, // Write address
   input wire logic awvalid, // Write address valid
   output logic awready, // Write address ready
   input wire logic [31:0] wdata, // Write data
   input wire logic [3:0] wstrb, // Write byte strobes
   input wire logic wvalid, // Write data valid
   output logic wready, // Write data ready
   output logic [1:0] bresp, // Write response
   output logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   input wire logic [3:0] araddr, // Read address
   input wire logic arvalid, // Read address valid
   output logic arready, // Read address ready
   output logic [31:0] rdata, // Read data
   output logic [1:0] rresp, // Read response
   output logic rvalid, // Read data valid
   input wire logic rready, // Read data ready
   input wire logic ce_a, // Enable of block clock A
   input wire logic ce_b, // Enable of block clock B
   input wire logic out_clr, // Output register clear, async, high
   input wire logic wr_en, // Write strobe
   input wire logic [8:0] wr_addr, // Write address
   input wire logic [17:0] wr_data, // Write data
   input wire logic rd_en, // Read strobe
   input wire logic [8:0] rd_addr, // Read address
   output logic [17:0] rd_data, // Read data
   output logic fifo_full, // FIFO full
   output logic fifo_empty // FIFO empty
);
   sdr_pkg::sdr_rbus_t rbus;
   sdr_pkg::sdr_rresp_t rans;
   sdr_pkg::sdr_ctrl_t ctrl_r;
   logic [`SDR_BITS-1:0] mem_r, wmask, wvec;
   logic [4:0] wid;
   logic [9:0] dep;
   logic ce_w, ce_r, ce_o;
   logic is_fifo, is_shift, is_rom, is_sp;
   logic wen_r;
   logic [8:0] wadr_r, radr_r, wptr_r, rptr_r, wptr_nxt, rptr_nxt;
   logic [17:0] wdat_r, mem_q, wd_eff;
   logic [`SDR_CW-1:0] cnt_r;
   logic push, pop, init_wr;
   logic [8:0] wsel_adr;
   logic [17:0] wsel_dat;
   logic wsel_en;
   logic [17:0] rd_data_r;
   logic full_r, empty_r;

   sdr_axil u_axil (
      .clock(clock),
      .rstn(rstn),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .rbus(rbus),
      .rans(rans)
   );

   // ==========================================================
   // Shape decode
   always_comb begin
      unique case (ctrl_r.width)
         3'h0: begin wid = 5'd1; dep = 10'd512; end
         3'h1: begin wid = 5'd2; dep = 10'd256; end
         3'h2: begin wid = 5'd4; dep = 10'd128; end
         3'h3: begin wid = 5'd8; dep = 10'd64; end
         3'h4: begin wid = 5'd9; dep = 10'd64; end
         3'h5: begin wid = 5'd16; dep = 10'd32; end
         default: begin wid = 5'd18; dep = 10'd32; end
      endcase
   end

   assign is_sp = ctrl_r.mode == sdr_pkg::SDR_MODE_SP;
   assign is_fifo = ctrl_r.mode == sdr_pkg::SDR_MODE_FIFO;
   assign is_rom = ctrl_r.mode == sdr_pkg::SDR_MODE_ROM;
   assign is_shift = ctrl_r.mode == sdr_pkg::SDR_MODE_SHIFT;

   // Clock groups: both block clocks are enables on the one system clock
   assign ce_w = ctrl_r.wr_clk_sel ? ce_b : ce_a;
   assign ce_r = ctrl_r.rd_clk_sel ? ce_b : ce_a;
   assign ce_o = ctrl_r.out_clk_sel ? ce_b : ce_a;

   // ==========================================================
   // Register file
   always_ff @(posedge clock) begin
      if (!rstn) begin
         ctrl_r <= `SDR_CTRL_RST;
      end else if (rbus.wr && rbus.waddr == `SDR_OFS_CTRL) begin
         if (rbus.wstrb[0]) begin
            ctrl_r[7:0] <= rbus.wdata[7:0];
         end
         if (rbus.wstrb[1]) begin
            ctrl_r[11:8] <= rbus.wdata[11:8];
         end
      end
   end

   // Preload only while stopped, so it never races the fabric port
   assign init_wr = rbus.wr && rbus.waddr == `SDR_OFS_INIT && !ctrl_r.run
      && (rbus.wstrb == 4'hf) && !is_fifo && !is_shift;

   always_comb begin
      rans.werr = rbus.waddr != `SDR_OFS_CTRL && rbus.waddr != `SDR_OFS_INIT;
      rans.rerr = 1'b0;
      rans.rdata = 32'h0;
      // Answer only while a read is pending; the slave samples it then
      if (rbus.rd) begin
         unique case (rbus.raddr)
            `SDR_OFS_CTRL: rans.rdata = {20'h0, ctrl_r};
            `SDR_OFS_INIT: rans.rdata = 32'h0;
            `SDR_OFS_STAT: rans.rdata = {19'h0, ctrl_r.run, empty_r, full_r, cnt_r};
            default: rans.rerr = 1'b1;
         endcase
      end
   end

   // ==========================================================
   // Write-side input registers, all on the write clock group
   assign push = ce_w && wr_en && ctrl_r.run && !is_rom && !(is_fifo && full_r);
   assign pop = ce_r && rd_en && ctrl_r.run && is_fifo && !empty_r;
   assign wptr_nxt = (10'(wptr_r) + 10'd1 >= dep) ? 9'h0 : wptr_r + 9'h1;
   assign rptr_nxt = (10'(rptr_r) + 10'd1 >= dep) ? 9'h0 : rptr_r + 9'h1;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         wen_r <= 1'b0;
         wadr_r <= 9'h0;
         wdat_r <= 18'h0;
      end else begin
         wen_r <= push;
         if (ce_w) begin
            wadr_r <= (is_fifo || is_shift) ? wptr_r : wr_addr;
            wdat_r <= wr_data;
         end
      end
   end

   // Pointers restart whenever the block is stopped
   always_ff @(posedge clock) begin
      if (!rstn || !ctrl_r.run) begin
         wptr_r <= 9'h0;
         rptr_r <= 9'h0;
         cnt_r <= 10'h0;
      end else begin
         if (push && (is_fifo || is_shift)) begin
            wptr_r <= wptr_nxt;
         end
         if (pop) begin
            rptr_r <= rptr_nxt;
         end
         if (is_fifo) begin
            cnt_r <= cnt_r + 10'(push) - 10'(pop);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn || !ctrl_r.run) begin
         full_r <= 1'b0;
         empty_r <= 1'b1;
      end else begin
         // Outside FIFO use the flags rest, so RAM writes never flicker them
         full_r <= is_fifo && (cnt_r + 10'(push) - 10'(pop)) == dep;
         empty_r <= !is_fifo || (cnt_r + 10'(push) - 10'(pop)) == 10'h0;
      end
   end

   // ==========================================================
   // Array write: one port, either the fabric or the preload path
   assign wsel_en = wen_r || init_wr;
   assign wsel_adr = init_wr ? rbus.wdata[26:`SDR_INIT_ADDR_LSB] : wadr_r;
   assign wsel_dat = init_wr ? rbus.wdata[17:0] : wdat_r;

   // Without parity the ninth bit of each byte stores zero
   always_comb begin
      wd_eff = wsel_dat;
      if (!ctrl_r.par_en && wid == 5'd9) begin
         wd_eff[8] = 1'b0;
      end
      if (!ctrl_r.par_en && wid == 5'd18) begin
         wd_eff[8] = 1'b0;
         wd_eff[17] = 1'b0;
      end
   end

   always_comb begin
      int off;
      off = int'(wsel_adr) * int'(wid);
      wmask = '0;
      wvec = '0;
      for (int i = 0; i < `SDR_DW; i++) begin
         if (wsel_en && i < int'(wid) && 10'(wsel_adr) < dep && off + i < `SDR_BITS) begin
            wmask[off + i] = 1'b1;
            wvec[off + i] = wd_eff[i];
         end
      end
   end

   // Contents are kept across reset so a preloaded image survives it
   always_ff @(posedge clock) begin
      mem_r <= (mem_r & ~wmask) | (wvec & wmask);
   end

   // ==========================================================
   // Read-side input register on the read clock group
   always_ff @(posedge clock) begin
      if (!rstn) begin
         radr_r <= 9'h0;
      end else if (is_fifo) begin
         if (pop) begin
            radr_r <= rptr_r;
         end
      end else if (ce_r && (rd_en || is_shift)) begin
         // Shift mode taps the oldest slot, the next one to be overwritten
         radr_r <= is_shift ? wptr_r : (is_sp ? wr_addr : rd_addr);
      end
   end

   // Same address on both ports in one cycle reads the old data
   always_comb begin
      int off;
      off = int'(radr_r) * int'(wid);
      mem_q = 18'h0;
      for (int i = 0; i < `SDR_DW; i++) begin
         if (i < int'(wid) && off + i < `SDR_BITS) begin
            mem_q[i] = mem_r[off + i];
         end
      end
   end

   // ==========================================================
   // Output register; bypass still passes one port flop
   always_ff @(posedge clock or posedge out_clr) begin
      if (out_clr) begin
         rd_data_r <= 18'h0;
      end else if (!rstn) begin
         rd_data_r <= 18'h0;
      end else if (ctrl_r.out_bypass) begin
         rd_data_r <= mem_q;
      end else if (ce_o) begin
         rd_data_r <= mem_q;
      end
   end

   assign rd_data = rd_data_r;
   assign fifo_full = full_r;
   assign fifo_empty = empty_r;

endmodule

`default_nettype wire

/* File: src/sdr_consts.svh */
`ifndef SDR_CONSTS_SVH
`define SDR_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define SDR_OFS_CTRL 4'h0
`define SDR_OFS_INIT 4'h4
`define SDR_OFS_STAT 4'h8

// ==========================================================
// Array size, widths and field positions
`define SDR_BITS 576
`define SDR_AW 9
`define SDR_DW 18
`define SDR_CW 10
`define SDR_INIT_ADDR_LSB 18
`define SDR_CTRL_RST 12'h000
`define SDR_RESP_OKAY 2'h0
`define SDR_RESP_SLVERR 2'h2

`endif

/* File: src/sdr_pkg.sv */
`default_nettype none
package sdr_pkg;

   // ==========================================================
   // Operating modes, as held in the control register
   typedef enum logic [2:0] {
      SDR_MODE_SDP = 3'h0,
      SDR_MODE_SP = 3'h1,
      SDR_MODE_FIFO = 3'h2,
      SDR_MODE_ROM = 3'h3,
      SDR_MODE_SHIFT = 3'h4
   } sdr_mode_t;

   // ==========================================================
   // Control register layout, bit 0 at the bottom
   typedef struct packed {
      logic run;
      logic par_en;
      logic out_bypass;
      logic out_clk_sel;
      logic rd_clk_sel;
      logic wr_clk_sel;
      logic [2:0] width;
      logic [2:0] mode;
   } sdr_ctrl_t;

   // ==========================================================
   // Register strobes from the bus slave and the answer back
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] waddr;
      logic [3:0] raddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
   } sdr_rbus_t;

   typedef struct packed {
      logic [31:0] rdata;
      logic rerr;
      logic werr;
   } sdr_rresp_t;

endpackage
`default_nettype wire

/* File: src/sdr_axil.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sdr_consts.svh"

module sdr_axil (
   input wire logic clock, // System clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic [3:0] awaddr, // Write address
   input wire logic awvalid, // Write address valid
   output logic awready, // Write address ready
   input wire logic [31:0] wdata, // Write data
   input wire logic [3:0] wstrb, // Write byte strobes
   input wire logic wvalid, // Write data valid
   output logic wready, // Write data ready
   output logic [1:0] bresp, // Write response
   output logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   input wire logic [3:0] araddr, // Read address
   input wire logic arvalid, // Read address valid
   output logic arready, // Read address ready
   output logic [31:0] rdata, // Read data
   output logic [1:0] rresp, // Read response
   output logic rvalid, // Read data valid
   input wire logic rready, // Read data ready
   output var sdr_pkg::sdr_rbus_t rbus, // Register strobes
   input wire sdr_pkg::sdr_rresp_t rans // Register answer
);
   logic aw_full_r, w_full_r, ar_full_r;
   logic [3:0] awaddr_r, araddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic awready_r, wready_r, arready_r, bvalid_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;

   // ==========================================================
   // Write path: address and data may come in either order
   always_ff @(posedge clock) begin
      if (!rstn) begin
         aw_full_r <= 1'b0;
         awready_r <= 1'b0;
         awaddr_r <= 4'h0;
      end else if (awvalid && awready_r) begin
         aw_full_r <= 1'b1;
         awready_r <= 1'b0;
         awaddr_r <= awaddr;
      end else if (bvalid_r && bready) begin
         aw_full_r <= 1'b0;
         awready_r <= 1'b1;
      end else if (!aw_full_r) begin
         awready_r <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         w_full_r <= 1'b0;
         wready_r <= 1'b0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
      end else if (wvalid && wready_r) begin
         w_full_r <= 1'b1;
         wready_r <= 1'b0;
         wdata_r <= wdata;
         wstrb_r <= wstrb;
      end else if (bvalid_r && bready) begin
         w_full_r <= 1'b0;
         wready_r <= 1'b1;
      end else if (!w_full_r) begin
         wready_r <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         bvalid_r <= 1'b0;
         bresp_r <= `SDR_RESP_OKAY;
      end else if (aw_full_r && w_full_r && !bvalid_r) begin
         bvalid_r <= 1'b1;
         bresp_r <= rans.werr ? `SDR_RESP_SLVERR : `SDR_RESP_OKAY;
      end else if (bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ==========================================================
   // Read path: one read in flight
   always_ff @(posedge clock) begin
      if (!rstn) begin
         ar_full_r <= 1'b0;
         arready_r <= 1'b0;
         araddr_r <= 4'h0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= `SDR_RESP_OKAY;
      end else begin
         if (arvalid && arready_r) begin
            ar_full_r <= 1'b1;
            arready_r <= 1'b0;
            araddr_r <= araddr;
         end else if (rvalid_r && rready) begin
            ar_full_r <= 1'b0;
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
         end else if (!ar_full_r) begin
            arready_r <= 1'b1;
         end
         if (ar_full_r && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r <= rans.rdata;
            rresp_r <= rans.rerr ? `SDR_RESP_SLVERR : `SDR_RESP_OKAY;
         end
      end
   end

   // One driver for the whole strobe bundle
   assign rbus = '{wr: aw_full_r && w_full_r && !bvalid_r, rd: ar_full_r && !rvalid_r,
      waddr: awaddr_r, raddr: araddr_r, wdata: wdata_r, wstrb: wstrb_r};
   assign awready = awready_r;
   assign wready = wready_r;
   assign arready = arready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;

endmodule

`default_nettype wire

/* File: test/sdr_ram_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sdr_consts.svh"

module sdr_ram_monitor (
   input wire logic clock, // System clock
   input wire logic rstn, // Sync reset
   input wire logic [3:0] awaddr, // Write address
   input wire logic awvalid, // Aw valid
   input wire logic awready, // Aw ready
   input wire logic wvalid, // W valid
   input wire logic wready, // W ready
   input wire logic [1:0] bresp, // Write response
   input wire logic bvalid, // B valid
   input wire logic bready, // B ready
   input wire logic arvalid, // Ar valid
   input wire logic arready, // Ar ready
   input wire logic [31:0] rdata, // Read data
   input wire logic [1:0] rresp, // Read response
   input wire logic rvalid, // R valid
   input wire logic rready, // R ready
   input wire logic out_clr, // Output clear
   input wire logic [17:0] rd_data, // Array read data
   input wire logic fifo_full, // Full flag
   input wire logic fifo_empty // Empty flag
);
   logic aw_bad_r;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   // ==========================================================
   // Remember whether the accepted write address is mapped
   always_ff @(posedge clock) begin
      if (!rstn) begin
         aw_bad_r <= 1'b0;
      end else if (awvalid && awready) begin
         aw_bad_r <= (awaddr != `SDR_OFS_CTRL) && (awaddr != `SDR_OFS_INIT);
      end
   end

   // ==========================================================
   // Bus and port behaviour
   a_reset_quiet: assert property (@(posedge clock) disable iff (1'b0) !rstn |=>
      !bvalid && !rvalid && !awready && !arready && fifo_empty && rd_data == 18'h0)
      else $error("outputs not quiet after reset");
   a_bresp_soon: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("write response late");
   a_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   a_wr_code: assert property ($rose(bvalid) |->
      bresp == (aw_bad_r ? `SDR_RESP_SLVERR : `SDR_RESP_OKAY))
      else $error("wrong write response code");
   a_rvalid_soon: assert property (arvalid && arready |-> ##[1:3] rvalid)
      else $error("read data late");
   a_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read data dropped");
   a_one_write: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while response pending");
   a_clear_out: assert property (out_clr |-> rd_data == 18'h0)
      else $error("output not cleared");
   a_flags_excl: assert property (!(fifo_full && fifo_empty))
      else $error("fifo full and empty together");
endmodule

bind sdr_ram sdr_ram_monitor u_mon (.clock(clock), .rstn(rstn), .awaddr(awaddr),
   .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
   .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
   .rresp(rresp), .rvalid(rvalid), .rready(rready), .out_clr(out_clr), .rd_data(rd_data),
   .fifo_full(fifo_full), .fifo_empty(fifo_empty));

`default_nettype wire

/* File: test/sdr_fab.sv */
`timescale 1ns/1ps
`default_nettype none

module sdr_fab (
   input wire logic clock, // System clock
   output logic ce_a, // Clock A enable
   output logic ce_b, // Clock B enable
   output logic out_clr, // Output clear
   output logic wr_en, // Write strobe
   output logic [8:0] wr_addr, // Write address
   output logic [17:0] wr_data, // Write data
   output logic rd_en, // Read strobe
   output logic [8:0] rd_addr // Read address
);
   initial begin
      ce_a = 1'b1;
      ce_b = 1'b1;
      out_clr = 1'b0;
      wr_en = 1'b0;
      wr_addr = 9'h0;
      wr_data = 18'h0;
      rd_en = 1'b0;
      rd_addr = 9'h0;
   end

   // Released lines show the inverse so a stale value never looks valid
   task automatic put(input logic [8:0] a, input logic [17:0] d);
      @(posedge clock);
      wr_en <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge clock);
      wr_en <= 1'b0;
      wr_addr <= ~a;
      wr_data <= ~d;
   endtask

   task automatic set_ce(input logic a, input logic b);
      ce_a <= a;
      ce_b <= b;
   endtask

   task automatic set_clr(input logic c);
      out_clr <= c;
   endtask

   // Single-port reads take their address from the write address lines
   task automatic sp_get(input logic [8:0] a);
      @(posedge clock);
      rd_en <= 1'b1;
      wr_addr <= a;
      @(posedge clock);
      rd_en <= 1'b0;
      wr_addr <= ~a;
      repeat (3) @(posedge clock);
   endtask

   // Waits long enough for either output clocking scheme
   task automatic get(input logic [8:0] a);
      @(posedge clock);
      rd_en <= 1'b1;
      rd_addr <= a;
      @(posedge clock);
      rd_en <= 1'b0;
      rd_addr <= ~a;
      repeat (3) @(posedge clock);
   endtask
endmodule

`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sdr_consts.svh"

module testbench;
   logic clock, rstn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, resp;
   logic ce_a, ce_b, out_clr, wr_en, rd_en, fifo_full, fifo_empty;
   logic [8:0] wr_addr, rd_addr;
   logic [17:0] wr_data, rd_data;
   int failures = 0;
   int n_checks = 0;

   sdr_ram dut (.clock, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .ce_a, .ce_b, .out_clr, .wr_en, .wr_addr, .wr_data, .rd_en, .rd_addr, .rd_data,
      .fifo_full, .fifo_empty);
   sdr_fab fab (.clock, .ce_a, .ce_b, .out_clr, .wr_en, .wr_addr, .wr_data, .rd_en, .rd_addr);

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // ==========================================================
   // Bus master and comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      resp = bresp;
   endtask

   task automatic axr(input logic [3:0] a);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      rd = rdata;
      resp = rresp;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_regs();
      for (int m = 0; m < 5; m++) begin
         axw(`SDR_OFS_CTRL, m);
         axr(`SDR_OFS_CTRL);
         chk(rd, m);
      end
      axw(`SDR_OFS_CTRL, 32'h0f0b, 4'h1);
      axr(`SDR_OFS_CTRL);
      chk(rd, 32'h00b);
      axw(`SDR_OFS_CTRL, 32'h0a00, 4'h2);
      axr(`SDR_OFS_CTRL);
      chk(rd, 32'ha0b);
      axr(4'hc);
      chk(rd, 32'h0);
      chk(resp, `SDR_RESP_SLVERR);
      axw(`SDR_OFS_STAT, 32'h0);
      chk(resp, `SDR_RESP_SLVERR);
      axr(`SDR_OFS_INIT);
      chk(rd, 32'h0);
   endtask

   task automatic t_preload();
      axw(`SDR_OFS_CTRL, 32'h433);
      axw(`SDR_OFS_INIT, {5'h0, 9'h3, 18'h2abcd});
      axw(`SDR_OFS_INIT, {5'h0, 9'h3, 18'h11111}, 4'h7);
      chk(resp, `SDR_RESP_OKAY);
      axw(`SDR_OFS_CTRL, 32'hc33);
      axw(`SDR_OFS_INIT, {5'h0, 9'h3, 18'h11111});
      fab.put(9'h3, 18'h1);
      fab.get(9'h3);
      chk(rd_data, 18'h2abcd);
   endtask

   task automatic t_ram();
      axw(`SDR_OFS_CTRL, 32'hc30);
      fab.put(9'h7, 18'h3ffff);
      fab.put(9'h8, 18'h0);
      fab.get(9'h7);
      chk(rd_data, 18'h3ffff);
      fab.set_ce(1'b0, 1'b1);
      fab.put(9'h8, 18'h15555);
      fab.set_ce(1'b1, 1'b1);
      axw(`SDR_OFS_CTRL, 32'hc70);
      fab.set_ce(1'b1, 1'b0);
      fab.put(9'h8, 18'h15555);
      fab.get(9'h8);
      chk(rd_data, 18'h0);
      fab.set_clr(1'b1);
      @(posedge clock);
      fab.set_clr(1'b0);
      axw(`SDR_OFS_CTRL, 32'he30);
      fab.get(9'h7);
      chk(rd_data, 18'h3ffff);
      axw(`SDR_OFS_CTRL, 32'hd30);
      fab.get(9'h8);
      chk(rd_data, 18'h3ffff);
      fab.set_ce(1'b1, 1'b1);
      repeat (3) @(posedge clock);
      chk(rd_data, 18'h0);
      fab.get(9'h7);
      fab.set_clr(1'b1);
      repeat (2) @(posedge clock);
      chk(rd_data, 18'h0);
      fab.set_clr(1'b0);
   endtask

   task automatic t_shape();
      axw(`SDR_OFS_CTRL, 32'hc00);
      fab.put(9'h1ff, 18'h1);
      fab.put(9'h1fe, 18'h0);
      fab.get(9'h1ff);
      chk(rd_data, 18'h1);
      fab.get(9'h1fe);
      chk(rd_data, 18'h0);
      axw(`SDR_OFS_CTRL, 32'h820);
      fab.put(9'h2, 18'h1ff);
      fab.get(9'h2);
      chk(rd_data, 18'h0ff);
   endtask

   task automatic t_fifo();
      axw(`SDR_OFS_CTRL, 32'h432);
      axw(`SDR_OFS_CTRL, 32'hc32);
      for (int i = 0; i < 33; i++) fab.put(9'h0, 18'h100 + i);
      axr(`SDR_OFS_STAT);
      chk(rd, 32'h1420);
      chk(fifo_full, 1'b1);
      fab.get(9'h0);
      chk(rd_data, 18'h100);
   endtask

   // Mid-run reset keeps the array, then single-port and shift use
   task automatic t_modes();
      @(posedge clock);
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      axr(`SDR_OFS_STAT);
      chk(rd, 32'h800);
      axw(`SDR_OFS_CTRL, 32'hc30);
      fab.get(9'h7);
      chk(rd_data, 18'h107);
      axw(`SDR_OFS_CTRL, 32'hc31);
      fab.put(9'h9, 18'h2468);
      fab.sp_get(9'h9);
      chk(rd_data, 18'h2468);
      axw(`SDR_OFS_CTRL, 32'hc34);
      fab.put(9'h0, 18'h3);
      @(posedge clock);
      chk(fifo_empty, 1'b1);
      repeat (2) @(posedge clock);
      chk(rd_data, 18'h101);
   endtask

   // ==========================================================
   // Verdict
   task automatic close_out();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      #100000;
      failures++;
      close_out();
   end

   initial begin
      rstn = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = 4'h0;
      araddr = 4'h0;
      wdata = 32'h0;
      wstrb = 4'hf;
      repeat (10) @(posedge clock);
      chk({bvalid, rvalid, fifo_empty, rd_data}, {3'b001, 18'h0});
      rstn <= 1'b1;
      t_regs();
      t_preload();
      t_ram();
      t_shape();
      t_fifo();
      t_modes();
      close_out();
   end
endmodule

`default_nettype wire
